// ### hdl/bams_pkg.sv
// shared constants and types of the bridge converter mode sequencer
package bams_pkg;
	// ==========================================
	// clock and timing
	localparam int unsigned CLK_HZ = 125_000_000; // system clock rate
	localparam int unsigned FILL_PERIODS = 22; // pipeline periods per fill
	localparam int unsigned FILL_RATE_HZ = 150; // filter fill rate
	// fill wait in clock cycles, rounded down
	localparam longint unsigned FILL_CYC =
		longint'(CLK_HZ) * FILL_PERIODS / FILL_RATE_HZ;
	localparam int FILL_W = 25; // counter width for the fill wait
	localparam int unsigned CFG_BITS = 8; // bits per config word
	localparam int unsigned SAMP_W = 24; // converter sample width
	localparam int unsigned NCONV = 4; // converters on the board

	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00; // session and mode control
	localparam logic [7:0] OFS_KEYS = 8'h04; // analog key settings
	localparam logic [7:0] OFS_STAT = 8'h08; // sequencer state
	localparam logic [7:0] OFS_DATA = 8'h0C; // sample stream, pops fifo

	// control and key register fields
	localparam int CTL_RUN = 0; // acquisition running
	localparam int CTL_MODE_LO = 1; // two-bit mode field
	localparam int CTL_ALT = 3; // alternating excitation
	localparam int CTL_AMP = 4; // 1 selects 5 V excitation
	localparam int KEY_IN_LO = 0; // five input switch keys
	localparam int KEY_TU_LO = 8; // four test unbalance keys
	localparam logic [4:0] CTRL_RST = 5'h00; // control after reset
	localparam logic [4:0] INKEY_RST = 5'h00; // input keys after reset
	localparam logic [3:0] TUKEY_RST = 4'h0; // test keys after reset

	// config word bit positions, msb first on the wire
	localparam int CW_PAIR = 7; // 1 selects second input pair
	localparam int CW_ENABLE_A = 6; // chopped measurement
	localparam int CW_SKIP = 5; // second stage filter on
	localparam int CW_FRST = 4; // filter reset

	// ==========================================
	// types
	typedef enum logic [1:0] {
		BAMS_MED4,
		BAMS_HIGH4,
		BAMS_HIGH8,
		BAMS_RSVD
	} bams_mode_e;

	// settings captured at session start
	typedef struct packed {
		bams_mode_e mode;
		logic alt;
		logic amp5;
	} bams_cfg_s;

	// word pushed into the sample stream
	typedef struct packed {
		logic [2:0] chan;
		logic pol;
		logic [3:0] zero;
		logic [SAMP_W-1:0] data;
	} bams_word_s;

	typedef logic [NCONV-1:0][SAMP_W-1:0] bams_samp_t;
endpackage

// ### hdl/bams_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module bams_fifo #(
	parameter int W = 32,
	parameter int D = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	// storage and pointers
	logic [W-1:0] mem_q [D];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] cnt_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// honest full and empty from the count
	assign in_ready = (cnt_q != (AW+1)'(D));
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rp_q];

	// pointer and count update
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// data store, no reset needed
	always_ff @(posedge clk) begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
endmodule

// ### hdl/bams_seq.sv
// bridge converter mode sequencer with apb registers
//
// Notes on behaviour
// R01: medium mode: first pair, no second filter
// R02: high accuracy modes: chopped, converter filtering
// R03: alt off: enable_a input, constant excitation
// R04: alt on: reverse excitation polarity periodically
// R05: polarity toggles once per acquired sample
// R06: eight channel half-cycle: first pair, reset
// R07: common start, then wait 22 periods
// R08: read samples before changing channel settings
// R09: then second pair, reset, repeat forever
// R10: eight channel rate about 3.4 Hz
// R11: input switch keys change only when idle
// R12: four independent test unbalance keys
// R13: software selects 2.5 V or 5 V
// R14: serial config, shared start line
// R15: mode settings latched at session start
// R16: reversal happens on a sample boundary
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module bams_seq
	import bams_pkg::*;
#(
	parameter longint unsigned FILL_CYCLES = bams_pkg::FILL_CYC
) (
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter serial config, shared by all four
	output logic cfg_cs_n,
	output logic cfg_sclk,
	output logic cfg_sdata,
	// shared start line, one cycle pulse
	output logic conv_start,
	// all converters have a sample
	input wire logic conv_drdy,
	input wire bams_pkg::bams_samp_t conv_data,
	// excitation supply control
	output logic bridge_excitation_supply,
	output logic exc_5v,
	// analog keys
	output logic [4:0] input_switch_keys,
	output logic [3:0] test_unbalance_keys
);
	import bams_pkg::*;

	// ==========================================
	// declarations
	typedef enum logic [2:0] {
		S_IDLE,
		S_SEND,
		S_START,
		S_FILL,
		S_WAIT,
		S_READ
	} bams_state_e;

	bams_state_e st_q, st_d; // sequencer state
	logic [4:0] ctrl_q; // control register
	logic [4:0] inkey_q; // input switch keys
	logic [3:0] tukey_q; // test unbalance keys
	bams_cfg_s act_q; // settings of the running session
	bams_cfg_s act_d; // settings as they stand after this edge
	logic pair_q; // second input pair active
	logic pair_d; // input pair after this edge
	logic pol_q; // excitation polarity
	logic [7:0] sh_q; // config shift register
	logic [3:0] bit_q; // config half-bit counter
	logic [FILL_W-1:0] fill_q; // fill wait counter
	logic [1:0] idx_q; // converter being pushed
	logic [31:0] rdata_q; // registered read data
	logic dv_q; // data read returned a real word
	logic start_q; // start pulse
	bams_samp_t samp_q; // captured samples

	// ==========================================
	// bus decode
	wire setup = psel && !penable;
	wire acc = psel && penable;
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_keys = (paddr == OFS_KEYS);
	wire hit_stat = (paddr == OFS_STAT);
	wire hit_data = (paddr == OFS_DATA);
	wire hit_any = hit_ctrl || hit_keys || hit_stat || hit_data;
	wire wr_ctrl = acc && pwrite && hit_ctrl;
	wire wr_keys = acc && pwrite && hit_keys;
	wire rd_data = acc && !pwrite && hit_data;
	wire run = ctrl_q[CTL_RUN];
	wire idle = (st_q == S_IDLE);

	// zero wait states; unmapped or write to read-only errors
	assign pready = 1'b1;
	assign pslverr = acc && (!hit_any || (pwrite && (hit_stat
		|| hit_data)));
	assign prdata = rdata_q;

	// ==========================================
	// fifo in the sample path
	bams_word_s push_w;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [31:0] fifo_out_data;
	wire push_v = (st_q == S_READ);
	wire push_ok = push_v && fifo_in_ready;
	wire last_push = push_ok && (idx_q == 2'(NCONV-1));
	wire pop_ok = rd_data && dv_q; // pop only the word handed out

	assign push_w.chan = {pair_q, idx_q};
	assign push_w.pol = pol_q;
	assign push_w.zero = 4'h0;
	assign push_w.data = samp_q[idx_q];

	bams_fifo #(
		.W(32),
		.D(4)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(push_v),
		.in_ready(fifo_in_ready),
		.in_data(push_w),
		.out_valid(fifo_out_valid),
		.out_ready(pop_ok),
		.out_data(fifo_out_data)
	);

	// ==========================================
	// mode decode of the running session
	// next-edge settings, so a session's first word is right
	assign act_d.mode = (idle && run) ?
		bams_mode_e'(ctrl_q[CTL_MODE_LO +: 2]) : act_q.mode;
	assign act_d.alt = (idle && run) ? ctrl_q[CTL_ALT] : act_q.alt;
	assign act_d.amp5 = (idle && run) ? ctrl_q[CTL_AMP] : act_q.amp5;
	wire high8 = (act_d.mode == BAMS_HIGH8);
	// R02 high modes: enable_a and filter
	wire high = (act_d.mode == BAMS_HIGH4) || high8;
	// R04 alternation only in high modes
	wire alt_on = high && act_q.alt;

	// config word for the converters
	logic [7:0] cw;
	// R01 medium mode word
	// R10 pairs swap per readout, quads half a period apart
	assign pair_d = idle ? 1'b0 : ((last_push && high8) ? !pair_q : pair_q);
	assign cw[CW_PAIR] = high8 && pair_d;
	assign cw[CW_ENABLE_A] = high;
	assign cw[CW_SKIP] = high;
	// R06 filter reset each half-cycle
	assign cw[CW_FRST] = 1'b1;
	assign cw[3:0] = 4'h0;

	// ==========================================
	// read data, captured in the setup phase
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (setup) begin
			if (hit_ctrl)
				rdata_q <= {27'h0, ctrl_q};
			else if (hit_keys)
				rdata_q <= {20'h0, tukey_q, 3'h0, inkey_q};
			else if (hit_stat)
				rdata_q <= {24'h0, 1'b0, fifo_out_valid, act_q.mode,
					!fifo_in_ready, pair_q, pol_q, !idle};
			else if (hit_data)
				rdata_q <= fifo_out_valid ? fifo_out_data : 32'h0;
			else
				rdata_q <= 32'h0000_0000;
		end
	end

	// remembers whether the setup phase saw a word to return
	always_ff @(posedge clk) begin
		if (rst)
			dv_q <= 1'b0;
		else if (setup)
			dv_q <= hit_data && fifo_out_valid;
	end

	// ==========================================
	// control register, free to write at any time
	always_ff @(posedge clk) begin
		if (rst)
			ctrl_q <= CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= pwdata[4:0];
	end

	// key register
	always_ff @(posedge clk) begin
		if (rst) begin
			inkey_q <= INKEY_RST;
			tukey_q <= TUKEY_RST;
		end else if (wr_keys && idle) begin
			// R11 keys ignored while running
			inkey_q <= pwdata[KEY_IN_LO +: 5];
			// R12 one test key per converter
			tukey_q <= pwdata[KEY_TU_LO +: 4];
		end
	end

	// ==========================================
	// sequencer next state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			S_IDLE: begin
				if (run)
					st_d = S_SEND;
			end
			S_SEND: begin
				// R14 serial config then start
				if (bit_q == 4'(2*CFG_BITS-1))
					st_d = S_START;
			end
			S_START: begin
				// R07 fill wait only in eight channel
				st_d = high8 ? S_FILL : S_WAIT;
			end
			S_FILL: begin
				if (!run)
					st_d = S_IDLE;
				else if (fill_q == FILL_W'(FILL_CYCLES-1))
					st_d = S_WAIT;
			end
			S_WAIT: begin
				if (!run)
					st_d = S_IDLE;
				else if (conv_drdy)
					st_d = S_READ;
			end
			S_READ: begin
				// R08 all four pushed before a change
				if (last_push) begin
					if (!run)
						st_d = S_IDLE;
					// R09 next half-cycle reconfigures
					else if (high8)
						st_d = S_SEND;
					else
						st_d = S_WAIT;
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst)
			st_q <= S_IDLE;
		else
			st_q <= st_d;
	end

	// ==========================================
	// session settings captured on leaving idle
	always_ff @(posedge clk) begin
		if (rst) begin
			act_q <= '0;
		end else if (idle && run) begin
			// R15 latch only at session start
			act_q <= act_d;
		end
	end

	// input pair selection
	always_ff @(posedge clk) begin
		if (rst)
			pair_q <= 1'b0;
		else
			// R09 swap pairs after each readout in eight channel mode
			pair_q <= pair_d;
	end

	// ==========================================
	// config shifter, one bit per two clocks
	always_ff @(posedge clk) begin
		if (rst) begin
			sh_q <= 8'h00;
			bit_q <= 4'h0;
		end else if (st_q != S_SEND) begin
			// R06 word loaded before each send
			sh_q <= cw;
			bit_q <= 4'h0;
		end else begin
			bit_q <= bit_q + 4'h1;
			if (bit_q[0])
				sh_q <= {sh_q[6:0], 1'b0};
		end
	end

	// R14 serial pins, data changes with clock low
	assign cfg_cs_n = (st_q != S_SEND);
	assign cfg_sclk = (st_q == S_SEND) && bit_q[0];
	assign cfg_sdata = (st_q == S_SEND) && sh_q[7];

	// ==========================================
	// common start pulse
	always_ff @(posedge clk) begin
		if (rst)
			start_q <= 1'b0;
		else
			// R07 one start for all converters
			start_q <= (st_q == S_START);
	end
	assign conv_start = start_q;

	// fill wait counter
	always_ff @(posedge clk) begin
		if (rst || st_q != S_FILL)
			fill_q <= '0;
		else
			// R07 count the fill time
			fill_q <= fill_q + 1'b1;
	end

	// ==========================================
	// sample capture and push index
	always_ff @(posedge clk) begin
		if (rst) begin
			samp_q <= '0;
			idx_q <= 2'h0;
		end else begin
			if (st_q == S_WAIT && conv_drdy)
				samp_q <= conv_data;
			if (st_q != S_READ)
				idx_q <= 2'h0;
			else if (push_ok)
				idx_q <= idx_q + 2'h1;
		end
	end

	// ==========================================
	// excitation polarity
	always_ff @(posedge clk) begin
		if (rst || idle || !alt_on)
			// R03 constant polarity without alternation
			pol_q <= 1'b0;
		// R05 R16 flip once per sample, at its end
		else if (last_push)
			pol_q <= !pol_q;
	end
	// R04 reversing supply drive
	assign bridge_excitation_supply = pol_q;

	// R13 amplitude select
	assign exc_5v = idle ? ctrl_q[CTL_AMP] : act_q.amp5;

	// analog key outputs
	assign input_switch_keys = inkey_q;
	assign test_unbalance_keys = tukey_q;
endmodule

// ### sim/bams_seq_assertions.sv
// port checker for the mode sequencer
`timescale 1ns/1ps
module bams_seq_assertions
	import bams_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cfg_cs_n,
	input wire logic cfg_sclk,
	input wire logic conv_start,
	input wire logic bridge_excitation_supply,
	input wire logic exc_5v,
	input wire logic [4:0] input_switch_keys,
	input wire logic [3:0] test_unbalance_keys
);
	// ==========================================
	// helpers
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [4:0] low_q; // cycles with select low
	wire acc = psel && penable; // access phase
	wire kw = acc && pwrite && paddr == OFS_KEYS; // key write
	// count the length of each config frame
	always_ff @(posedge clk) begin
		if (rst || cfg_cs_n) low_q <= 5'h00;
		else low_q <= low_q + 5'h01;
	end
	// ==========================================
	// assertions
	a_cfg_len: assert property (
		$rose(cfg_cs_n) |-> low_q == 5'h10) else $error("bad frame length");
	a_start_one: assert property (
		conv_start |=> !conv_start) else $error("start pulse too long");
	a_start_free: assert property (
		conv_start |-> cfg_cs_n) else $error("start during config");
	a_sclk_idle: assert property (
		cfg_cs_n |-> !cfg_sclk) else $error("serial clock not idle");
	a_keys_gate: assert property (
		$changed(input_switch_keys) |-> $past(kw)) else $error("key change");
	a_test_gate: assert property (
		$changed(test_unbalance_keys) |-> $past(kw)) else $error("test key");
	a_amp_steady: assert property (
		!cfg_cs_n && $past(!cfg_cs_n) |-> $stable(exc_5v))
		else $error("amplitude moved");
	a_pol_edge: assert property (
		$changed(bridge_excitation_supply) |->
		$past(cfg_cs_n && !conv_start))
		else $error("polarity moved mid config");
	a_bad_addr: assert property (
		acc && paddr > OFS_DATA |-> pslverr && prdata == 32'h0)
		else $error("unmapped access");
	a_ready_one: assert property (pready) else $error("ready low");
	cover property (conv_start);
	cover property (kw);
	cover property (acc && pslverr);
endmodule

// ### sim/bams_conv_model.sv
// behavioural model of the four bridge converters
`timescale 1ns/1ps
module bams_conv_model
	import bams_pkg::*;
#(
	parameter int PER = 40
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_cs_n,
	input wire logic cfg_sclk,
	input wire logic cfg_sdata,
	input wire logic conv_start,
	output logic conv_drdy,
	output bams_pkg::bams_samp_t conv_data
);
	logic [7:0] sh_q, cw_q; // shifter, last word
	logic sclk_q, cs_q, run_q; // edge history, running
	int cnt_q; // cycles since start or last sample
	// serial capture on rising serial clock
	always_ff @(posedge clk) begin
		sclk_q <= cfg_sclk;
		cs_q <= cfg_cs_n;
		if (!cfg_cs_n && cfg_sclk && !sclk_q) sh_q <= {sh_q[6:0], cfg_sdata};
		if (cfg_cs_n && !cs_q) cw_q <= sh_q;
		if (rst) cw_q <= 8'h00;
	end
	// common start, then one sample set per period
	always_ff @(posedge clk) begin
		if (rst) begin
			run_q <= 1'b0;
			cnt_q <= 0;
			conv_drdy <= 1'b0;
		end else begin
			if (conv_start) begin
				run_q <= cw_q[CW_FRST];
				cnt_q <= 0;
			end else if (run_q) cnt_q <= (cnt_q == PER - 1) ? 0 : cnt_q + 1;
			conv_drdy <= run_q && !conv_start && cnt_q == PER - 1;
		end
	end
	// data echo the setting word, scrambled outside ready
	always_comb begin
		for (int i = 0; i < NCONV; i++) begin
			conv_data[i] = {cw_q, 14'h0, 2'(i)};
			if (!conv_drdy) conv_data[i] = ~conv_data[i];
		end
	end
endmodule

// ### sim/test_bams_seq.sv
// self-checking bench for the mode sequencer
`timescale 1ns/1ps
module test_bams_seq;
	import bams_pkg::*;
	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic cs_n, sclk, sdata, start, drdy, pol, exc5;
	bams_samp_t cdata;
	logic [4:0] ik;
	logic [3:0] tk;
	int err_count, comparisons;
	bams_seq #(.FILL_CYCLES(20)) dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_cs_n(cs_n),
		.cfg_sclk(sclk), .cfg_sdata(sdata), .conv_start(start),
		.conv_drdy(drdy), .conv_data(cdata), .bridge_excitation_supply(pol),
		.exc_5v(exc5), .input_switch_keys(ik), .test_unbalance_keys(tk));
	bams_conv_model conv (.clk(clk), .rst(rst), .cfg_cs_n(cs_n),
		.cfg_sclk(sclk), .cfg_sdata(sdata), .conv_start(start),
		.conv_drdy(drdy), .conv_data(cdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic give_verdict;
		if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, got);
		comparisons++;
		if (got !== ex) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// one apb transfer, held until ready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll a status bit, bounded
	task automatic wait_stat(input int b, input logic v);
		logic [31:0] q;
		logic e;
		for (int i = 0; i < 500; i++) begin
			apb(1'b0, OFS_STAT, 32'h0, q, e);
			if (q[b] === v) return;
		end
		chk("status bit", {31'h0, v}, {31'h0, !v});
	endtask
	initial begin
		logic [31:0] q, k, w;
		logic e, hi, pr;
		logic [7:0] cw;
		int s;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_count = 0;
		comparisons = 0;
		void'($urandom(31));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		chk("ctrl reset", 32'h0, q);
		apb(1'b0, OFS_KEYS, 32'h0, q, e);
		chk("keys reset", 32'h0, q);
		apb(1'b0, OFS_STAT, 32'h0, q, e);
		chk("stat reset", 32'h0, q);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk("unmapped", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		apb(1'b1, OFS_STAT, 32'hFF, q, e);
		chk("ro write", 32'h1, {31'h0, e});
		for (int a = 0; a < 2; a++) for (int m = 0; m < 4; m++) begin
			k = $urandom & 32'h0F1F;
			apb(1'b1, OFS_KEYS, k, q, e);
			apb(1'b0, OFS_KEYS, 32'h0, q, e);
			chk("keys idle", k, q);
			w = {27'h0, 1'($urandom), 1'(a), 2'(m), 1'b1};
			apb(1'b1, OFS_CTRL, w, q, e);
			#1 chk("amplitude", {31'h0, w[4]}, {31'h0, exc5});
			wait_stat(0, 1'b1);
			apb(1'b1, OFS_KEYS, ~k, q, e);
			apb(1'b0, OFS_KEYS, 32'h0, q, e);
			chk("keys busy", k, q);
			apb(1'b1, OFS_CTRL, w ^ 32'h10, q, e);
			#1 chk("amp held", {31'h0, w[4]}, {31'h0, exc5});
			hi = m == 1 || m == 2;
			for (int n = 0; n < 12; n++) begin
				wait_stat(6, 1'b1);
				apb(1'b0, OFS_DATA, 32'h0, q, e);
				s = n / 4;
				pr = m == 2 && s[0];
				cw = hi ? {pr, 7'h70} : 8'h10;
				chk("word", {pr, 2'(n % 4), w[3] && hi && s[0], 4'h0,
					cw, 14'h0, 2'(n % 4)}, q);
			end
			apb(1'b1, OFS_CTRL, 32'h0, q, e);
			wait_stat(0, 1'b0);
			for (int n = 0; n < 8; n++) begin
				apb(1'b0, OFS_STAT, 32'h0, q, e);
				if (q[6]) apb(1'b0, OFS_DATA, 32'h0, q, e);
			end
			apb(1'b0, OFS_DATA, 32'h0, q, e);
			chk("empty pop", 32'h0, q);
		end
		give_verdict;
	end
	initial begin
		repeat (50000) @(posedge clk);
		err_count++;
		give_verdict;
	end
endmodule
bind bams_seq bams_seq_assertions chk (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cfg_cs_n(cfg_cs_n),
	.cfg_sclk(cfg_sclk), .conv_start(conv_start),
	.bridge_excitation_supply(bridge_excitation_supply), .exc_5v(exc_5v),
	.input_switch_keys(input_switch_keys),
	.test_unbalance_keys(test_unbalance_keys));
